// File: core/rtepv_pkg.sv
/*
  Constants for the retimer equaliser and pattern-verifier register bank:
  register offsets, field positions, reset values and code meanings.
  Assumes one register clock shared by the register port and the lane joins.
*/
package rtepv_pkg;

  localparam int unsigned RTEPV_LANES = 4;

  // Register offsets on the target port
  localparam logic [7:0] RTEPV_ADDR_EQUALISER_CONTROL     = 8'h0D;
  localparam logic [7:0] RTEPV_ADDR_VERIFIER_SYNC_LOAD    = 8'h0E;
  localparam logic [7:0] RTEPV_ADDR_VERIFIER_FAIL_PROG    = 8'h0F;
  localparam logic [7:0] RTEPV_ADDR_VERIFIER_PATTERN_CFG  = 8'h10;
  localparam logic [7:0] RTEPV_ADDR_CUSTOM_PATTERN_LOW    = 8'h11;
  localparam logic [7:0] RTEPV_ADDR_CUSTOM_PATTERN_MID    = 8'h12;
  localparam logic [7:0] RTEPV_ADDR_CUSTOM_PATTERN_HIGH   = 8'h13;

  // Equaliser control fields
  localparam int unsigned RTEPV_EQ_DATA_MSB      = 5;
  localparam int unsigned RTEPV_EQ_DATA_LSB      = 3;
  localparam int unsigned RTEPV_EQ_CLK_MSB       = 2;
  localparam int unsigned RTEPV_EQ_CLK_LSB       = 1;
  localparam int unsigned RTEPV_EQ_FULL_SWING    = 0;

  // Pattern configuration fields
  localparam int unsigned RTEPV_CFG_CP20         = 7;
  localparam int unsigned RTEPV_CFG_LEN_MSB      = 5;
  localparam int unsigned RTEPV_CFG_LEN_LSB      = 3;
  localparam int unsigned RTEPV_CFG_SEL_MSB      = 2;
  localparam int unsigned RTEPV_CFG_SEL_LSB      = 0;

  // Reset values
  localparam logic [7:0]  RTEPV_EQ_RESET         = 8'h00;
  localparam logic [19:0] RTEPV_CP_RESET         = 20'h00000;
  localparam logic [3:0]  RTEPV_NIBBLE_RESET     = 4'h0;
  localparam logic [4:0]  RTEPV_DEGREE_RESET     = 5'h07;

  // Custom pattern lengths in bits
  localparam logic [4:0]  RTEPV_CP_BITS_SHORT    = 5'h10;
  localparam logic [4:0]  RTEPV_CP_BITS_LONG     = 5'h14;

  // Checker mode decoded from the pattern-select field
  typedef enum logic [2:0] {
    RTEPV_MODE_OFF,
    RTEPV_MODE_PRBS,
    RTEPV_MODE_CLOCK,
    RTEPV_MODE_CUSTOM,
    RTEPV_MODE_TIMING
  } rtepv_mode_e;

endpackage

// File: core/rtepv_lane_hold.sv
/*
  One receive lane's copy of the pattern-verifier settings, plus decoding of
  the incoming select and length codes into a mode and a PRBS polynomial degree.
  Assumes load, settings and lane all run on the register clock.
*/
module rtepv_lane_hold
  import rtepv_pkg::*;
#(
  parameter int unsigned TIMEOUT_W = 8
) (
  input  wire logic                 clk_in,
  input  wire logic                 rst_b_in,
  input  wire logic                 lane_settings_load_in,
  input  wire logic [TIMEOUT_W-1:0] checker_timeout_in,
  input  wire logic [2:0]           checker_pattern_select_in,
  input  wire logic [2:0]           prbs_length_select_in,
  input  wire logic                 custom_length_twenty_in,
  input  wire logic [19:0]          custom_pattern_word_in,
  output logic [TIMEOUT_W-1:0]      held_timeout_out,
  output rtepv_mode_e               held_mode_out,
  output logic [4:0]                held_prbs_degree_out,
  output logic [4:0]                held_custom_bits_out,
  output logic [19:0]               held_custom_word_out
);

  typedef struct packed {
    logic [TIMEOUT_W-1:0] timeout;
    rtepv_mode_e          mode;
    logic [4:0]           degree;
    logic [4:0]           bits;
    logic [19:0]          word;
  } rtepv_hold_s;

  rtepv_hold_s state;
  rtepv_hold_s next_state;

  // Follow the register fields while load is high, keep them once it drops;
  // decoding on the way in lets every lane output come straight from a flop
  always_comb begin
    next_state = state;
    if (lane_settings_load_in) begin
      next_state.timeout = checker_timeout_in;
      // Select code; any code with the top bit set is timing only
      case (checker_pattern_select_in)
        3'h0:    next_state.mode = RTEPV_MODE_OFF;
        3'h1:    next_state.mode = RTEPV_MODE_PRBS;
        3'h2:    next_state.mode = RTEPV_MODE_CLOCK;
        3'h3:    next_state.mode = RTEPV_MODE_CUSTOM;
        default: next_state.mode = RTEPV_MODE_TIMING;
      endcase
      // Polynomial degree; also sets sync spacing in timing-only mode
      case (prbs_length_select_in)
        3'h0:    next_state.degree = 5'h07;
        3'h1:    next_state.degree = 5'h0B;
        3'h2:    next_state.degree = 5'h17;
        3'h3:    next_state.degree = 5'h1F;
        3'h4,
        3'h5:    next_state.degree = 5'h0F;
        default: next_state.degree = 5'h14;
      endcase
      next_state.bits = custom_length_twenty_in ? RTEPV_CP_BITS_LONG : RTEPV_CP_BITS_SHORT;
      // Top nibble is masked in 16-bit mode so a stale value cannot leak in
      next_state.word = {custom_pattern_word_in[19:16] & {4{custom_length_twenty_in}},
                         custom_pattern_word_in[15:0]};
    end
  end

  // Reset shows the decode of all-zero settings: off, PRBS7, 16-bit pattern
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state        <= '0;
      state.degree <= RTEPV_DEGREE_RESET;
      state.bits   <= RTEPV_CP_BITS_SHORT;
    end else begin
      state <= next_state;
    end
  end

  assign held_timeout_out     = state.timeout;
  assign held_mode_out        = state.mode;
  assign held_prbs_degree_out = state.degree;
  assign held_custom_bits_out = state.bits;
  assign held_custom_word_out = state.word;

endmodule

// File: core/rtepv_regs.sv
/*
  Register bank for the fixed equaliser control and the per-lane pattern
  verifier. Holds the registers, the read mux, the equaliser gain decode and
  one settings holder per receive lane.
  Reserved equaliser bits 7:6 are stored and read back; other spare bits read zero.
  Assumes an I2C target elsewhere turns bus traffic into single-cycle read and
  write strobes on this clock, and that the lane checkers report on this clock.
*/
module rtepv_regs
  import rtepv_pkg::*;
#(
  parameter int unsigned LANES     = RTEPV_LANES,
  parameter int unsigned TIMEOUT_W = 8
) (
  input  wire logic                 clk_in,
  input  wire logic                 rst_b_in,
  input  wire logic [7:0]           reg_addr_in,
  input  wire logic                 reg_write_in,
  input  wire logic [7:0]           reg_wdata_in,
  input  wire logic                 reg_read_in,
  output logic [7:0]                reg_rdata_out,
  input  wire logic                 clock_ratio_flag_in,
  input  wire logic [TIMEOUT_W-1:0] checker_timeout_in,
  input  wire logic [LANES-1:0]     lane_cycle_wrap_in,
  input  wire logic [LANES-1:0]     lane_mismatch_in,
  input  wire logic [LANES-1:0]     lane_busy_in,
  output logic [5:0]                data_eq_half_db_out,
  output logic [3:0]                clock_eq_half_db_out,
  output logic                      clock_eq_reserved_out,
  output logic                      output_swing_half_out,
  output logic [LANES*TIMEOUT_W-1:0] lane_timeout_out,
  output rtepv_mode_e [LANES-1:0]   lane_mode_out,
  output logic [LANES*5-1:0]        lane_prbs_degree_out,
  output logic [LANES*5-1:0]        lane_custom_bits_out,
  output logic [LANES*20-1:0]       lane_custom_word_out
);

  // Whole bank state; the gain decode is registered so the analog controls never see a glitch
  typedef struct packed {
    logic [7:0]       eq;
    logic [LANES-1:0] load;
    logic [LANES-1:0] load_prev;
    logic [LANES-1:0] sync;
    logic [LANES-1:0] fail;
    logic [LANES-1:0] busy;
    logic             cp20;
    logic [2:0]       len;
    logic [2:0]       sel;
    logic [19:0]      cp;
    logic [7:0]       rdata;
    logic [5:0]       data_eq;
    logic [3:0]       clk_eq;
    logic             clk_rsvd;
    logic             swing_half;
  } rtepv_regs_s;

  rtepv_regs_s state;
  rtepv_regs_s next_state;

  // Combinational views, rebuilt every cycle from the registered state
  logic [7:0] read_word;
  logic [3:0] sync_nib;
  logic [3:0] load_nib;
  logic [3:0] fail_nib;
  logic [3:0] busy_nib;

  // Nibble views, bit n is lane n, spare lanes read as zero
  always_comb begin
    sync_nib = '0;
    load_nib = '0;
    fail_nib = '0;
    busy_nib = '0;
    for (int n = 0; n < LANES && n < 4; n++) begin
      sync_nib[n] = state.sync[n];
      load_nib[n] = state.load[n];
      fail_nib[n] = state.fail[n];
      busy_nib[n] = state.busy[n];
    end
  end

  // Read mux; unmapped offsets read zero
  // Status nibbles are read as registered, one clock behind the lanes
  always_comb begin
    case (reg_addr_in)
      RTEPV_ADDR_EQUALISER_CONTROL:    read_word = state.eq;
      RTEPV_ADDR_VERIFIER_SYNC_LOAD:   read_word = {sync_nib, load_nib};
      RTEPV_ADDR_VERIFIER_FAIL_PROG:   read_word = {fail_nib, busy_nib};
      RTEPV_ADDR_VERIFIER_PATTERN_CFG: read_word = {state.cp20, 1'b0, state.len, state.sel};
      RTEPV_ADDR_CUSTOM_PATTERN_LOW:   read_word = state.cp[7:0];
      RTEPV_ADDR_CUSTOM_PATTERN_MID:   read_word = state.cp[15:8];
      RTEPV_ADDR_CUSTOM_PATTERN_HIGH:  read_word = {4'h0, state.cp[19:16]};
      default:                         read_word = 8'h00;
    endcase
  end

  // Register writes, lane status capture and equaliser decode
  always_comb begin
    next_state = state;
    if (reg_write_in) begin
      case (reg_addr_in)
        RTEPV_ADDR_EQUALISER_CONTROL:    next_state.eq = reg_wdata_in;
        RTEPV_ADDR_VERIFIER_SYNC_LOAD:   next_state.load = reg_wdata_in[LANES-1:0];
        RTEPV_ADDR_VERIFIER_PATTERN_CFG: begin
          next_state.cp20 = reg_wdata_in[RTEPV_CFG_CP20];
          next_state.len  = reg_wdata_in[RTEPV_CFG_LEN_MSB:RTEPV_CFG_LEN_LSB];
          next_state.sel  = reg_wdata_in[RTEPV_CFG_SEL_MSB:RTEPV_CFG_SEL_LSB];
        end
        RTEPV_ADDR_CUSTOM_PATTERN_LOW:   next_state.cp[7:0]   = reg_wdata_in;
        RTEPV_ADDR_CUSTOM_PATTERN_MID:   next_state.cp[15:8]  = reg_wdata_in;
        RTEPV_ADDR_CUSTOM_PATTERN_HIGH:  next_state.cp[19:16] = reg_wdata_in[3:0];
        default: ;
      endcase
    end
    // Previous load level finds the rising edge that clears a lane's failure
    next_state.load_prev = state.load;
    // Sync bit shows the generator wrap for one register clock
    next_state.sync = lane_cycle_wrap_in;
    // Failure is sticky; a fresh load clears it, a same-cycle mismatch wins
    next_state.fail = (state.fail & ~(state.load & ~state.load_prev)) | lane_mismatch_in;
    // Busy is not latched, so it drops one register clock after the lane goes idle
    next_state.busy = lane_busy_in;
    // Read data is captured only on a read strobe and stands until the next one
    if (reg_read_in) begin
      next_state.rdata = read_word;
    end
    // Gains follow the live clock-ratio flag, so a mode change retunes without a rewrite
    next_state.data_eq    = data_gain(state.eq[RTEPV_EQ_DATA_MSB:RTEPV_EQ_DATA_LSB], clock_ratio_flag_in);
    next_state.clk_rsvd   = 1'b0;
    case (state.eq[RTEPV_EQ_CLK_MSB:RTEPV_EQ_CLK_LSB])
      2'h0:    next_state.clk_eq = 4'h0;
      2'h1:    next_state.clk_eq = 4'h3;
      2'h2:    next_state.clk_eq = 4'h6;
      default: begin
        // Reserved in lower-rate mode: apply no gain rather than guess
        next_state.clk_eq   = clock_ratio_flag_in ? 4'h9 : 4'h0;
        next_state.clk_rsvd = ~clock_ratio_flag_in;
      end
    endcase
    next_state.swing_half = ~state.eq[RTEPV_EQ_FULL_SWING] & clock_ratio_flag_in;
  end

  // Asynchronous clear; named reset values are kept explicit for the reader
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state    <= '0;
      state.eq <= RTEPV_EQ_RESET;
      state.cp <= RTEPV_CP_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Data-lane gain in half-dB steps; every printed figure is a whole half dB
  function automatic logic [5:0] data_gain(input logic [2:0] code, input logic high_rate);
    logic [5:0] g;
    // Lower-rate codes first, then the high-rate codes
    case ({high_rate, code})
      4'h0:    g = 6'h00;
      4'h1:    g = 6'h09;
      4'h2:    g = 6'h0D;
      4'h3:    g = 6'h11;
      4'h4:    g = 6'h15;
      4'h5:    g = 6'h18;
      4'h6:    g = 6'h1C;
      4'h7:    g = 6'h21;
      4'h8:    g = 6'h00;
      4'h9:    g = 6'h06;
      4'hA:    g = 6'h0A;
      4'hB:    g = 6'h0F;
      4'hC:    g = 6'h13;
      4'hD:    g = 6'h16;
      4'hE:    g = 6'h1A;
      default: g = 6'h1D;
    endcase
    return g;
  endfunction

  // Every data output is a flop, so downstream controls see clean levels
  assign reg_rdata_out         = state.rdata;
  assign data_eq_half_db_out   = state.data_eq;
  assign clock_eq_half_db_out  = state.clk_eq;
  assign clock_eq_reserved_out = state.clk_rsvd;
  assign output_swing_half_out = state.swing_half;

  // One settings holder per receive lane
  for (genvar n = 0; n < LANES; n++) begin : g_lane
    rtepv_lane_hold #(
      .TIMEOUT_W (TIMEOUT_W)
    ) u_hold (
      .clk_in                    (clk_in),
      .rst_b_in                  (rst_b_in),
      .lane_settings_load_in     (state.load[n]),
      .checker_timeout_in        (checker_timeout_in),
      .checker_pattern_select_in (state.sel),
      .prbs_length_select_in     (state.len),
      .custom_length_twenty_in   (state.cp20),
      .custom_pattern_word_in    (state.cp),
      .held_timeout_out          (lane_timeout_out[n*TIMEOUT_W +: TIMEOUT_W]),
      .held_mode_out             (lane_mode_out[n]),
      .held_prbs_degree_out      (lane_prbs_degree_out[n*5 +: 5]),
      .held_custom_bits_out      (lane_custom_bits_out[n*5 +: 5]),
      .held_custom_word_out      (lane_custom_word_out[n*20 +: 20])
    );
  end

endmodule

// File: dv/rtepv_sva.sv
/*
  Concurrent checks for the equaliser and pattern-verifier register bank.
  Assumes it is bound to the top module and sees only that module's ports.
*/
module rtepv_sva
  import rtepv_pkg::*;
#(
  parameter int unsigned LANES = RTEPV_LANES
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic [7:0]       reg_addr_in,
  input  wire logic             reg_write_in,
  input  wire logic [7:0]       reg_wdata_in,
  input  wire logic             reg_read_in,
  input  wire logic [7:0]       reg_rdata_out,
  input  wire logic             clock_ratio_flag_in,
  input  wire logic [LANES-1:0] lane_cycle_wrap_in,
  input  wire logic [LANES-1:0] lane_mismatch_in,
  input  wire logic [LANES-1:0] lane_busy_in,
  input  wire logic [5:0]       data_eq_half_db_out,
  input  wire logic             clock_eq_reserved_out,
  input  wire logic             output_swing_half_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  // Strobe decodes; status reads answer a cycle late, so inputs are looked at two back
  wire logic eq_wr = reg_write_in && reg_addr_in == RTEPV_ADDR_EQUALISER_CONTROL;
  wire logic rd_sl = reg_read_in && reg_addr_in == RTEPV_ADDR_VERIFIER_SYNC_LOAD;
  wire logic rd_fp = reg_read_in && reg_addr_in == RTEPV_ADDR_VERIFIER_FAIL_PROG;

  chk_data_gain_low: assert property (eq_wr && reg_wdata_in[5:3] == 3'h7 ##1 !clock_ratio_flag_in |=>
    data_eq_half_db_out == 6'h21) else $error("data gain top code in lower-rate mode");
  chk_data_gain_high: assert property (eq_wr && reg_wdata_in[5:3] == 3'h7 ##1 clock_ratio_flag_in |=>
    data_eq_half_db_out == 6'h1D) else $error("data gain top code in high-rate mode");
  chk_clock_code_reserved: assert property (eq_wr && reg_wdata_in[2:1] == 2'h3 ##1 !clock_ratio_flag_in |=>
    clock_eq_reserved_out) else $error("reserved clock code not flagged");
  chk_swing_full_kept: assert property (eq_wr && reg_wdata_in[0] |-> ##2 !output_swing_half_out)
    else $error("clock swing halved with full swing bit set");
  chk_swing_half_high: assert property (eq_wr && !reg_wdata_in[0] ##1 clock_ratio_flag_in |=>
    output_swing_half_out) else $error("clock swing not halved in high-rate mode");
  chk_sync_pulse_read: assert property (rd_sl |=> reg_rdata_out[7:4] == $past(lane_cycle_wrap_in, 2))
    else $error("sync nibble does not follow lane wraps");
  chk_fail_bit_set: assert property (rd_fp |=>
    (reg_rdata_out[7:4] & $past(lane_mismatch_in, 2)) == $past(lane_mismatch_in, 2))
    else $error("failure bit missing after mismatch");
  chk_busy_bit_follow: assert property (rd_fp |=> reg_rdata_out[3:0] == $past(lane_busy_in, 2))
    else $error("in-progress nibble does not follow lanes");
  chk_unmapped_reads_zero: assert property (reg_read_in && (reg_addr_in < 8'h0D || reg_addr_in > 8'h13) |=>
    reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!reg_read_in |=> $stable(reg_rdata_out))
    else $error("read data moved without a read");

  cover property (eq_wr ##1 clock_ratio_flag_in);
  cover property (rd_fp ##1 reg_rdata_out[7:4] != 4'h0);
  cover property (rd_sl ##1 reg_rdata_out[7:4] != 4'h0);
endmodule

// File: dv/testbench.sv
/*
  Self-checking bench for the equaliser and pattern-verifier register bank.
  Assumes single-cycle register strobes; inputs change at the falling edge.
*/
module testbench import rtepv_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_in = 1'h0, rst_b_in = 1'h0, reg_write_in = 1'h0, reg_read_in = 1'h0;
  logic              clock_ratio_flag_in = 1'h0, rd_seen = 1'h0, clock_eq_reserved_out, output_swing_half_out;
  logic [7:0]        reg_addr_in = 8'h00, reg_wdata_in = 8'h00, checker_timeout_in = 8'h00, reg_rdata_out, v;
  logic [3:0]        lane_cycle_wrap_in = 4'h0, lane_mismatch_in = 4'h0, lane_busy_in = 4'h0, clock_eq_half_db_out;
  logic [5:0]        data_eq_half_db_out;
  logic [31:0]       lane_timeout_out;
  rtepv_mode_e [3:0] lane_mode_out;
  logic [19:0]       lane_prbs_degree_out, lane_custom_bits_out, cp;
  logic [79:0]       lane_custom_word_out;
  logic [7:0]        exp_q[$];
  int                failures = 0, check_count = 0;

  rtepv_regs rtepv_regs_i (.clk_in, .rst_b_in, .reg_addr_in, .reg_write_in, .reg_wdata_in, .reg_read_in,
    .reg_rdata_out, .clock_ratio_flag_in, .checker_timeout_in, .lane_cycle_wrap_in, .lane_mismatch_in,
    .lane_busy_in, .data_eq_half_db_out, .clock_eq_half_db_out, .clock_eq_reserved_out, .output_swing_half_out,
    .lane_timeout_out, .lane_mode_out, .lane_prbs_degree_out, .lane_custom_bits_out, .lane_custom_word_out);

  always #2 clk_in = ~clk_in;

  task automatic check(input logic [19:0] seen, input logic [19:0] want);
    check_count++;
    if (seen !== want) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  // One register cycle per falling edge; a read notes its expected data
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    reg_write_in = w;
    reg_read_in = !w;
    reg_addr_in = a;
    reg_wdata_in = d;
    if (!w) exp_q.push_back(d);
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk_in);
      reg_write_in = 1'h0;
      reg_read_in = 1'h0;
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Read data lands one cycle after the strobe, so compare at the next falling edge
  always @(posedge clk_in) rd_seen <= reg_read_in;
  always @(negedge clk_in) if (rd_seen && exp_q.size() > 0) check(reg_rdata_out, exp_q.pop_front());

  // A hang is cut short and counted as a mismatch
  initial begin
    #200000;
    failures++;
    end_of_test;
  end

  initial begin
    static logic [7:0] msk [7] = '{8'hFF, 8'h0F, 8'h00, 8'hBF, 8'hFF, 8'hFF, 8'h0F};
    static logic [5:0] lo [8] = '{6'h00, 6'h09, 6'h0D, 6'h11, 6'h15, 6'h18, 6'h1C, 6'h21};
    static logic [5:0] hi [8] = '{6'h00, 6'h06, 6'h0A, 6'h0F, 6'h13, 6'h16, 6'h1A, 6'h1D};
    static logic [4:0] deg [8] = '{5'h07, 5'h0B, 5'h17, 5'h1F, 5'h0F, 5'h0F, 5'h14, 5'h14};
    logic [3:0] i4;
    logic [2:0] k;
    int ln;
    void'($urandom(2));
    repeat (12) @(posedge clk_in);
    @(negedge clk_in) rst_b_in = 1'h1;
    check(lane_custom_bits_out[4:0], 20'h00010);
    check(lane_prbs_degree_out[4:0], 20'h00007);
    for (int a = 13; a < 20; a++) op(1'h0, 8'(a), 8'h00);
    idle(2);
    $display("test reset values done");
    // Random write then read back at once; stored bits only, writes to status ignored
    for (int a = 13; a < 20; a++) begin
      v = 8'($urandom);
      op(1'h1, 8'(a), v);
      op(1'h0, 8'(a), v & msk[a-13]);
    end
    op(1'h1, 8'h40, 8'hA5);
    op(1'h0, 8'h40, 8'h00);
    op(1'h0, 8'h0C, 8'h00);
    idle(2);
    $display("test register access done");
    // Every data and clock code in both rate modes, with the swing bit toggling
    for (int i = 0; i < 16; i++) begin
      i4 = 4'(i);
      op(1'h1, RTEPV_ADDR_EQUALISER_CONTROL, {2'h0, i4[2:0], i4[1:0], i4[0]});
      clock_ratio_flag_in = i4[3];
      idle(3);
      check(data_eq_half_db_out, i4[3] ? hi[i4[2:0]] : lo[i4[2:0]]);
      check(clock_eq_half_db_out, i4[1:0] == 2'h3 ? (i4[3] ? 4'h9 : 4'h0) : 4'(i4[1:0] * 3));
      check(clock_eq_reserved_out, i4[1:0] == 2'h3 && !i4[3]);
      check(output_swing_half_out, !i4[0] && i4[3]);
    end
    $display("test equaliser done");
    // Load each select and length code into one lane, then change settings and expect them held
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      ln = i % 4;
      cp = 20'($urandom);
      op(1'h1, RTEPV_ADDR_CUSTOM_PATTERN_LOW, cp[7:0]);
      op(1'h1, RTEPV_ADDR_CUSTOM_PATTERN_MID, cp[15:8]);
      op(1'h1, RTEPV_ADDR_CUSTOM_PATTERN_HIGH, {4'h0, cp[19:16]});
      op(1'h1, RTEPV_ADDR_VERIFIER_PATTERN_CFG, {k[0], 1'h0, k, k});
      checker_timeout_in = cp[7:0];
      op(1'h1, RTEPV_ADDR_VERIFIER_SYNC_LOAD, 8'(1 << ln));
      op(1'h1, RTEPV_ADDR_VERIFIER_SYNC_LOAD, 8'h00);
      op(1'h1, RTEPV_ADDR_VERIFIER_PATTERN_CFG, ~{k[0], 1'h0, k, k});
      checker_timeout_in = ~cp[7:0];
      idle(3);
      check(lane_mode_out[ln], k[2] ? RTEPV_MODE_TIMING : rtepv_mode_e'(k));
      check(lane_prbs_degree_out[ln*5+:5], deg[k]);
      check(lane_custom_bits_out[ln*5+:5], k[0] ? 5'h14 : 5'h10);
      check(lane_custom_word_out[ln*20+:20], k[0] ? cp : {4'h0, cp[15:0]});
      check(lane_timeout_out[ln*8+:8], cp[7:0]);
    end
    $display("test lane load done");
    // Wrap, mismatch and busy on different lanes, then clear the failure by a load
    @(negedge clk_in);
    lane_busy_in = 4'h2;
    lane_mismatch_in = 4'h4;
    lane_cycle_wrap_in = 4'h8;
    op(1'h0, RTEPV_ADDR_VERIFIER_SYNC_LOAD, 8'h80);
    lane_cycle_wrap_in = 4'h0;
    lane_mismatch_in = 4'h0;
    op(1'h0, RTEPV_ADDR_VERIFIER_FAIL_PROG, 8'h42);
    op(1'h0, RTEPV_ADDR_VERIFIER_SYNC_LOAD, 8'h00);
    op(1'h1, RTEPV_ADDR_VERIFIER_SYNC_LOAD, 8'h04);
    op(1'h1, RTEPV_ADDR_VERIFIER_SYNC_LOAD, 8'h00);
    op(1'h0, RTEPV_ADDR_VERIFIER_FAIL_PROG, 8'h02);
    idle(3);
    $display("test lane status done");
    end_of_test;
  end
endmodule

bind rtepv_regs rtepv_sva #(.LANES(LANES)) rtepv_sva_i (.clk_in, .rst_b_in, .reg_addr_in, .reg_write_in,
  .reg_wdata_in, .reg_read_in, .reg_rdata_out, .clock_ratio_flag_in, .lane_cycle_wrap_in, .lane_mismatch_in,
  .lane_busy_in, .data_eq_half_db_out, .clock_eq_reserved_out, .output_swing_half_out);
